// ===== agpc_defines.vh
/*
  register indices, field positions, reset value and function codes of
  the auxiliary gpio pin configuration block.
  assumes inclusion by bare name from the design files.
*/
`ifndef AGPC_DEFINES_VH
`define AGPC_DEFINES_VH

// register indices
`define AGPC_IDX_P7_1        8'hD9
`define AGPC_IDX_P7_2        8'hDA
`define AGPC_IDX_P7_3        8'hDB
`define AGPC_IDX_P7_4        8'hDC
`define AGPC_IDX_P7_5        8'hDD
`define AGPC_IDX_P7_6        8'hDE
`define AGPC_IDX_P7_7        8'hDF
`define AGPC_IDX_P1_0        8'hE0
`define AGPC_IDX_P1_1        8'hE1
`define AGPC_IDX_P1_2        8'hE2
`define AGPC_IDX_P1_3        8'hE3
`define AGPC_IDX_P1_4        8'hE4
`define AGPC_IDX_P1_5        8'hE5
`define AGPC_IDX_P1_6        8'hE6
`define AGPC_IDX_P1_7        8'hE7
`define AGPC_IDX_P1_DATA     8'hF0
`define AGPC_IDX_P7_DATA     8'hF1

// register counts and slots
`define AGPC_NUM_CFG         15
`define AGPC_SLOT_NONE       4'hF
`define AGPC_SLOT_P1_BASE    7

// reset value and write masks
`define AGPC_CFG_RESET       8'h01
`define AGPC_MASK_FULL       8'hFF
`define AGPC_MASK_P1_MID     8'h0F
`define AGPC_MASK_P1_6       8'h1F

// field positions
`define AGPC_BIT_DIR         0
`define AGPC_BIT_POL         1
`define AGPC_BIT_IEN         2
`define AGPC_BIT_ALT         3
`define AGPC_FSEL_HI         4
`define AGPC_FSEL_LO         3
`define AGPC_IRQ_HI          7
`define AGPC_IRQ_LO          4

// function select codes
`define AGPC_FSEL_DEDICATED  2'h0
`define AGPC_FSEL_GPIO       2'h1
`define AGPC_JOY_READ        2'h1
`define AGPC_JOY_CS          2'h2

`endif

// ===== agpc_p1_cell.v
/*
  one port-1 pin: direction, polarity, interrupt contribution and the
  hand-over of the pin to an alternate function.
  assumes pin_sync is already synchronised to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

`include "agpc_defines.vh"

module agpc_p1_cell
(
  // configuration
  input  wire [7:0] cfg,
  input  wire       data_bit,
  // alternate function
  input  wire       alt_en,
  input  wire       alt_is_out,
  input  wire       alt_val,
  // pin
  input  wire       pin_sync,
  output reg        pin_out,
  output reg        pin_oe,
  // status
  output wire       level,
  output wire       irq_req
);

  // (R5) polarity on input
  assign level = pin_sync ^ cfg[`AGPC_BIT_POL];

  // (R6) interrupt enable gate
  assign irq_req = cfg[`AGPC_BIT_IEN] & level;

  always @*
  begin
    pin_out = 1'b0;
    pin_oe  = 1'b0;
    if (alt_en && alt_is_out)
    begin
      pin_out = alt_val;
      pin_oe  = 1'b1;
    end
    else if (!alt_en)
    begin
      // (R4) direction bit
      pin_oe  = ~cfg[`AGPC_BIT_DIR];
      // (R5) polarity on output
      pin_out = data_bit ^ cfg[`AGPC_BIT_POL];
    end
  end

endmodule // agpc_p1_cell

`default_nettype wire

// ===== agpc_pin_cfg.v
/*
  configuration registers and pin muxing for port-7 and port-1 pins of
  the auxiliary i/o device, with pin data and steered interrupt outputs.
  assumes a simple one-cycle register port on ref_clk and pins arriving
  asynchronously; peripheral signals come from logic on ref_clk.
*/
// Added by the designer: the strobed register port.
// Notes on behaviour
// (R1) port-7 bits 4:3 pick dedicated signal at 00, gpio at 01, reserved above.
// (R2) pins 7.1 to 7.7 carry carrier detect, rx, tx, dsr, rts, cts and dtr of serial 2.
// (R3) every configuration register loads 0x01 on the standby power-on reset.
// (R4) port-1 bit 0 makes the pin an input when set and an output when clear.
// (R5) port-1 bit 1 inverts the pin's logical sense when set.
// (R6) port-1 bit 2 lets the pin join the combined interrupt when set.
// (R7) pins 1.0 to 1.5 use bit 3 to pick the alternate function over basic i/o.
// (R8) pins 1.0 and 1.1 as inputs with alternate set drive the irq chosen by bits 7:4.
// (R9) pin 1.2 alternate is watchdog out, or infrared receive when ir option bit 6 is set.
// (R10) pin 1.3 alternate is power led, or infrared transmit when ir option bit 6 is set.
// (R11) pin 1.4 alternate drives the active-low address decode output.
// (R12) pin 1.5 alternate drives the active-low write strobe output.
// (R13) pin 1.6 bits 4:3 pick basic i/o, joystick read strobe or joystick chip select.
// (R14) reserved high bits of pins 1.2 to 1.6 always hold zero.
// (R15) the pin 7.1 register sits at index 0xD9.
// (R16) the combined interrupt is high while any enabled pin shows an active level.
`timescale 1ns/100ps
`default_nettype none

`include "agpc_defines.vh"

module agpc_pin_cfg
(
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // port-7 pins, bit 0 is pin 7.1
  input  wire [6:0]  p7_pin_in,
  output reg  [6:0]  p7_pin_out,
  output reg  [6:0]  p7_pin_oe,
  // port-1 pins
  input  wire [7:0]  p1_pin_in,
  output wire [7:0]  p1_pin_out,
  output wire [7:0]  p1_pin_oe,
  // second serial port
  output wire        serial2_carrier_detect_n,
  output wire        serial2_receive_data,
  output wire        serial2_data_set_ready_n,
  output wire        serial2_clear_to_send_n,
  input  wire        serial2_transmit_data,
  input  wire        serial2_request_to_send_n,
  input  wire        serial2_terminal_ready_n,
  // alternate function sources
  input  wire        ir_option_select,
  input  wire        watchdog_output,
  input  wire        power_led_output,
  input  wire        infrared_transmit_output,
  input  wire        addr_decode_n,
  input  wire        gp_write_strobe_n,
  input  wire        joystick_read_strobe_n,
  input  wire        joystick_chip_select_n,
  output wire        infrared_receive_input,
  // interrupts
  output reg  [15:0] host_irq,
  output reg         combined_irq
);

  // register index to storage slot, shared by write and read
  function [3:0] slot_of;
    input [7:0] idx;
    reg   [7:0] off;
    begin
      // offset fits four bits inside the mapped range
      off = idx - `AGPC_IDX_P7_1;
      // (R15) first slot at 0xD9
      if (idx >= `AGPC_IDX_P7_1 && idx <= `AGPC_IDX_P1_7)
        slot_of = off[3:0];
      else
        slot_of = `AGPC_SLOT_NONE;
    end
  endfunction

  // bits a slot can hold
  function [7:0] mask_of;
    input [3:0] slot;
    begin
      // (R14) reserved bits forced to zero
      if (slot >= 4'h9 && slot <= 4'hC)
        mask_of = `AGPC_MASK_P1_MID;
      else if (slot == 4'hD)
        mask_of = `AGPC_MASK_P1_6;
      else
        mask_of = `AGPC_MASK_FULL;
    end
  endfunction

  reg  [7:0] cfg_q [0:`AGPC_NUM_CFG-1];
  reg  [6:0] p7_data_q;
  reg  [7:0] p1_data_q;
  reg  [6:0] p7_meta_q;
  reg  [6:0] p7_sync_q;
  reg  [7:0] p1_meta_q;
  reg  [7:0] p1_sync_q;
  reg  [15:0] host_irq_d;
  reg  [7:0] rdata_d;
  wire [3:0] wr_slot;
  wire [3:0] rd_slot;
  wire [7:0] p1_level;
  wire [7:0] p1_irq_req;
  wire [6:0] p7_level;
  wire [6:0] p7_dedicated;
  wire [6:0] ser_out;
  wire [7:0] alt_en;
  wire [7:0] alt_is_out;
  wire [7:0] alt_val;
  wire [1:0] joy_sel;
  integer    i;

  assign wr_slot = slot_of(reg_addr);
  assign rd_slot = slot_of(reg_addr);

  // configuration and data registers
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      // (R3) standby reset value
      for (i = 0; i < `AGPC_NUM_CFG; i = i + 1)
        cfg_q[i] <= `AGPC_CFG_RESET;
      p7_data_q <= 7'h00;
      p1_data_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (wr_slot != `AGPC_SLOT_NONE)
        cfg_q[wr_slot] <= reg_wdata & mask_of(wr_slot);
      else if (reg_addr == `AGPC_IDX_P1_DATA)
        p1_data_q <= reg_wdata;
      else if (reg_addr == `AGPC_IDX_P7_DATA)
        p7_data_q <= reg_wdata[7:1];
    end
  end

  // two-stage synchronisers on every pin input
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      p7_meta_q <= 7'h00;
      p7_sync_q <= 7'h00;
      p1_meta_q <= 8'h00;
      p1_sync_q <= 8'h00;
    end
    else
    begin
      p7_meta_q <= p7_pin_in;
      p7_sync_q <= p7_meta_q;
      p1_meta_q <= p1_pin_in;
      p1_sync_q <= p1_meta_q;
    end
  end

  // read data valid in the cycle after the strobe only
  always @*
  begin
    rdata_d = 8'h00;
    if (rd_slot != `AGPC_SLOT_NONE)
      rdata_d = cfg_q[rd_slot];
    else if (reg_addr == `AGPC_IDX_P1_DATA)
      rdata_d = p1_level;
    else if (reg_addr == `AGPC_IDX_P7_DATA)
      rdata_d = {p7_level, 1'b0};
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 8'h00;
  end

  // (R2) serial 2 outputs placed on 7.3, 7.5 and 7.7
  assign ser_out = {serial2_terminal_ready_n, 1'b0, serial2_request_to_send_n, 1'b0,
                    serial2_transmit_data, 2'h0};

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1)
    begin : p7_pin
      wire [7:0] c = cfg_q[g];
      wire       is_out = (g == 2) || (g == 4) || (g == 6);
      // (R1) function select on bits 4:3
      assign p7_dedicated[g] = (c[`AGPC_FSEL_HI:`AGPC_FSEL_LO] == `AGPC_FSEL_DEDICATED);
      assign p7_level[g] = p7_sync_q[g] ^ c[`AGPC_BIT_POL];
      always @*
      begin
        p7_pin_out[g] = 1'b0;
        p7_pin_oe[g]  = 1'b0;
        if (p7_dedicated[g])
        begin
          p7_pin_out[g] = ser_out[g];
          p7_pin_oe[g]  = is_out;
        end
        // (R1) gpio mode, reserved codes leave pin idle
        else if (c[`AGPC_FSEL_HI:`AGPC_FSEL_LO] == `AGPC_FSEL_GPIO)
        begin
          p7_pin_out[g] = p7_data_q[g] ^ c[`AGPC_BIT_POL];
          p7_pin_oe[g]  = ~c[`AGPC_BIT_DIR];
        end
      end
    end
  endgenerate

  // (R2) serial 2 inputs idle high when the pin is not theirs
  assign serial2_carrier_detect_n = p7_dedicated[0] ? p7_sync_q[0] : 1'b1;
  assign serial2_receive_data     = p7_dedicated[1] ? p7_sync_q[1] : 1'b1;
  assign serial2_data_set_ready_n = p7_dedicated[3] ? p7_sync_q[3] : 1'b1;
  assign serial2_clear_to_send_n  = p7_dedicated[5] ? p7_sync_q[5] : 1'b1;

  assign joy_sel = cfg_q[13][`AGPC_FSEL_HI:`AGPC_FSEL_LO];

  // (R8) irq steering only while the pin is an input
  assign alt_en[0] = cfg_q[7][`AGPC_BIT_ALT] & cfg_q[7][`AGPC_BIT_DIR];
  assign alt_en[1] = cfg_q[8][`AGPC_BIT_ALT] & cfg_q[8][`AGPC_BIT_DIR];
  // (R7) alternate select on bit 3
  assign alt_en[2] = cfg_q[9][`AGPC_BIT_ALT];
  assign alt_en[3] = cfg_q[10][`AGPC_BIT_ALT];
  assign alt_en[4] = cfg_q[11][`AGPC_BIT_ALT];
  assign alt_en[5] = cfg_q[12][`AGPC_BIT_ALT];
  // (R13) joystick codes, code 11 falls back to basic i/o
  assign alt_en[6] = (joy_sel == `AGPC_JOY_READ) || (joy_sel == `AGPC_JOY_CS);
  // pin 1.7 alternate not covered here
  assign alt_en[7] = 1'b0;

  // (R9) infrared receive turns pin 1.2 into an input
  assign alt_is_out = {1'b0, 4'hF, ~ir_option_select, 2'h0};

  assign alt_val[0] = 1'b0;
  assign alt_val[1] = 1'b0;
  // (R9) watchdog output
  assign alt_val[2] = watchdog_output;
  // (R10) power led or infrared transmit
  assign alt_val[3] = ir_option_select ? infrared_transmit_output : power_led_output;
  // (R11) address decode, active low
  assign alt_val[4] = addr_decode_n;
  // (R12) write strobe, active low
  assign alt_val[5] = gp_write_strobe_n;
  // (R13) joystick strobes, active low
  assign alt_val[6] = (joy_sel == `AGPC_JOY_READ) ? joystick_read_strobe_n
                                                  : joystick_chip_select_n;
  assign alt_val[7] = 1'b0;

  // (R9) infrared receive path
  assign infrared_receive_input = (alt_en[2] & ir_option_select) ? p1_sync_q[2] : 1'b0;

  generate
    for (g = 0; g < 8; g = g + 1)
    begin : p1_pin
      agpc_p1_cell u_cell
      (
        .cfg        (cfg_q[`AGPC_SLOT_P1_BASE + g]),
        .data_bit   (p1_data_q[g]),
        .alt_en     (alt_en[g]),
        .alt_is_out (alt_is_out[g]),
        .alt_val    (alt_val[g]),
        .pin_sync   (p1_sync_q[g]),
        .pin_out    (p1_pin_out[g]),
        .pin_oe     (p1_pin_oe[g]),
        .level      (p1_level[g]),
        .irq_req    (p1_irq_req[g])
      );
    end
  endgenerate

  // code 0000 steers nowhere, so irq 0 is never driven
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : irq_map
      localparam [3:0] K = g;
      // (R8) irq number from bits 7:4
      always @*
      begin
        host_irq_d[g] = 1'b0;
        if (K != 4'h0)
          host_irq_d[g] =
            (alt_en[0] & p1_level[0] & (cfg_q[7][`AGPC_IRQ_HI:`AGPC_IRQ_LO] == K)) |
            (alt_en[1] & p1_level[1] & (cfg_q[8][`AGPC_IRQ_HI:`AGPC_IRQ_LO] == K));
      end
    end
  endgenerate

  // registered to keep glitches of the pin mux off the irq lines
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      host_irq     <= 16'h0000;
      combined_irq <= 1'b0;
    end
    else
    begin
      host_irq     <= host_irq_d;
      // (R16) combined interrupt is a level
      combined_irq <= |p1_irq_req;
    end
  end

endmodule // agpc_pin_cfg

`default_nettype wire

// ===== agpc_pin_cfg_asserts.sv
/*
  port checks for agpc_pin_cfg, bound to it.
  assumes the write shadow kept here mirrors the block's registers.
*/
`timescale 1ns/100ps
`default_nettype none

module agpc_pin_cfg_asserts
(
  // clock, reset and writes
  input wire        ref_clk,
  input wire        rst_n,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  // pins
  input wire [6:0]  p7_pin_in,
  input wire [6:0]  p7_pin_out,
  input wire [6:0]  p7_pin_oe,
  input wire [7:0]  p1_pin_in,
  input wire [7:0]  p1_pin_out,
  input wire [7:0]  p1_pin_oe,
  // functions and interrupts
  input wire        serial2_transmit_data,
  input wire        serial2_carrier_detect_n,
  input wire        watchdog_output,
  input wire        ir_option_select,
  input wire        joystick_chip_select_n,
  input wire [15:0] host_irq,
  input wire        combined_irq
);
  logic [7:0] sh_q [8'hD9:8'hE7];
  logic [1:0] up_q;
  logic       ien_any;

  // no reserved masking: reserved high bits of 0xE2 to 0xE6 are never looked at
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      for (int i = 8'hD9; i <= 8'hE7; i++)
        sh_q[i] <= 8'h01;
    else if (reg_wr && reg_addr >= 8'hD9 && reg_addr <= 8'hE7)
      sh_q[reg_addr] <= reg_wdata;
    up_q <= (!rst_n) ? 2'h0 : up_q + {1'h0, up_q != 2'h3};
  end

  always_comb
  begin
    ien_any = 1'h0;
    for (int i = 8'hE0; i <= 8'hE7; i++)
      ien_any = ien_any | sh_q[i][2];
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_reset_pins: assert property (
    $rose(rst_n) |-> p1_pin_oe == 8'h00 && p7_pin_oe == 7'h54)
    else $error("pin enables wrong after reset");
  a_tx_dedicated: assert property (
    sh_q[8'hDB][4:3] == 2'h0 |-> p7_pin_oe[2] && p7_pin_out[2] == serial2_transmit_data)
    else $error("tx pin not serial data");
  a_p7_reserved: assert property (sh_q[8'hDB][4] |-> !p7_pin_oe[2])
    else $error("reserved code drives pin");
  // sync flops need two edges out of reset
  a_dcd_follow: assert property (
    up_q[1] && sh_q[8'hD9][4:3] == 2'h0 |-> serial2_carrier_detect_n == $past(p7_pin_in[0], 2))
    else $error("carrier detect not from pin");
  a_p1_dir: assert property (p1_pin_oe[7] == !sh_q[8'hE7][0])
    else $error("direction bit ignored");
  a_wdog_alt: assert property (
    sh_q[8'hE2][3] |-> (ir_option_select ? !p1_pin_oe[2]
      : p1_pin_oe[2] && p1_pin_out[2] == watchdog_output))
    else $error("pin 1.2 alternate wrong");
  a_joy_cs: assert property (
    sh_q[8'hE6][4:3] == 2'h2 |-> p1_pin_oe[6] && p1_pin_out[6] == joystick_chip_select_n)
    else $error("joystick select not on pin");
  a_irq_steer: assert property (
    &up_q && $past(sh_q[8'hE0]) == 8'hF9 && $past(sh_q[8'hE1][7:4]) != 4'hF
    |-> host_irq[15] == $past(p1_pin_in[0], 3))
    else $error("irq 15 not steered");
  a_comb_off: assert property (!$past(ien_any) |-> !combined_irq)
    else $error("combined irq without enable");
endmodule // agpc_pin_cfg_asserts

bind agpc_pin_cfg agpc_pin_cfg_asserts i_chk
(
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .p7_pin_in(p7_pin_in), .p7_pin_out(p7_pin_out), .p7_pin_oe(p7_pin_oe),
  .p1_pin_in(p1_pin_in), .p1_pin_out(p1_pin_out), .p1_pin_oe(p1_pin_oe),
  .serial2_transmit_data(serial2_transmit_data),
  .serial2_carrier_detect_n(serial2_carrier_detect_n), .watchdog_output(watchdog_output),
  .ir_option_select(ir_option_select), .joystick_chip_select_n(joystick_chip_select_n),
  .host_irq(host_irq), .combined_irq(combined_irq)
);

`default_nettype wire

// ===== agpc_pin_cfg_tb.sv
/*
  self-checking bench for agpc_pin_cfg.
  assumes the pin model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none

module agpc_pin_cfg_tb;
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        ir = 1'h0;
  logic [7:0]  ad = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rdat;
  logic [6:0]  p7i, p7o, p7e;
  logic [7:0]  p1i, p1o, p1e;
  logic [6:0]  ext7 = 7'h00;
  logic [7:0]  ext1 = 8'h00;
  logic [9:0]  src = 10'h000;
  logic [15:0] hirq;
  logic        cd, rx, dsr, cts, irx, cirq;
  logic        pend = 1'h0;
  logic [31:0] lfsr = 32'h6C46;
  logic [7:0]  exp_q[$];
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  agpc_pin_cfg i_dut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .p7_pin_in(p7i), .p7_pin_out(p7o), .p7_pin_oe(p7e),
    .p1_pin_in(p1i), .p1_pin_out(p1o), .p1_pin_oe(p1e), .serial2_carrier_detect_n(cd),
    .serial2_receive_data(rx), .serial2_data_set_ready_n(dsr),
    .serial2_clear_to_send_n(cts), .serial2_transmit_data(src[0]),
    .serial2_request_to_send_n(src[1]), .serial2_terminal_ready_n(src[2]),
    .ir_option_select(ir), .watchdog_output(src[3]), .power_led_output(src[4]),
    .infrared_transmit_output(src[5]), .addr_decode_n(src[6]), .gp_write_strobe_n(src[7]),
    .joystick_read_strobe_n(src[8]), .joystick_chip_select_n(src[9]),
    .infrared_receive_input(irx), .host_irq(hirq), .combined_irq(cirq)
  );

  agpc_pin_env i_env
  (
    .p7_out(p7o), .p7_oe(p7e), .p1_out(p1o), .p1_oe(p1e),
    .ext7(ext7), .ext1(ext1), .p7_lvl(p7i), .p1_lvl(p1i)
  );

  initial forever #25 ref_clk = ~ref_clk;

  function logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one bus cycle; a read notes its expected data
  task op(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w)
      exp_q.push_back(d);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= d;
    @(posedge ref_clk);
  endtask

  // #1 lets the edge's updates land before looking
  task pause(input int n);
    wr <= 1'h0;
    rd <= 1'h0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  always @(negedge ref_clk)
  begin
    if (pend)
      chk("reg_rdata", rdat, exp_q.pop_front());
    pend = rd;
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      wrap_up;
    end
  end

  initial
  begin
    int k;
    logic [7:0] m;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    for (k = 8'hD9; k <= 8'hE7; k++)
      op(1'h0, k[7:0], 8'h01);
    op(1'h1, 8'hC0, 8'hFF);
    op(1'h0, 8'hC0, 8'h00);
    for (k = 8'hD9; k <= 8'hE7; k++)
    begin
      lfsr = nxt(lfsr);
      m = (k >= 8'hE2 && k <= 8'hE5) ? 8'h0F : (k == 8'hE6) ? 8'h1F : 8'hFF;
      op(1'h1, k[7:0], lfsr[7:0]);
      op(1'h0, k[7:0], lfsr[7:0] & m);
    end
    for (k = 8'hD9; k <= 8'hE7; k++)
      op(1'h1, k[7:0], 8'h01);
    for (k = 0; k < 4; k++)
    begin
      lfsr = nxt(lfsr);
      src <= lfsr[9:0];
      ext7 <= lfsr[16:10];
      op(1'h1, 8'hDA, {3'h0, k[1:0], 3'h0});
      op(1'h1, 8'hDB, {3'h0, k[1:0], 3'h0});
      pause(3);
      chk("tx_oe", p7e[2], k < 2);
      chk("rx", rx, k != 0 || ext7[1]);
      chk("ser_in", {cd, dsr, cts}, {ext7[0], ext7[3], ext7[5]});
      if (k == 0)
        chk("tx", p7o[2], src[0]);
    end
    op(1'h1, 8'hE7, 8'h00);
    op(1'h1, 8'hF0, 8'h80);
    pause(1);
    chk("p1_oe", p1e[7], 1'h1);
    chk("p1_out", p1o[7], 1'h1);
    ext1 <= 8'h80;
    op(1'h1, 8'hE7, 8'h07);
    pause(4);
    chk("comb_inv", cirq, 1'h0);
    ext1 <= 8'h00;
    pause(4);
    chk("comb_on", cirq, 1'h1);
    op(1'h1, 8'hE7, 8'h03);
    pause(2);
    chk("comb_off", cirq, 1'h0);
    lfsr = nxt(lfsr);
    src <= lfsr[9:0];
    for (k = 8'hE2; k <= 8'hE5; k++)
      op(1'h1, k[7:0], 8'h08);
    op(1'h1, 8'hE6, 8'h10);
    pause(1);
    chk("alt_oe", p1e[6:2], 5'h1F);
    chk("alt_out", p1o[6:2], {src[9], src[7:6], src[4:3]});
    ir <= 1'h1;
    ext1 <= 8'h04;
    op(1'h1, 8'hE6, 8'h08);
    pause(3);
    chk("infrared_receive_input_oe", p1e[2], 1'h0);
    chk("infrared_receive_input", irx, 1'h1);
    chk("ir_out", p1o[6:3], {src[8], src[7:6], src[5]});
    ir <= 1'h0;
    ext1 <= 8'h01;
    for (k = 1; k < 16; k++)
    begin
      op(1'h1, 8'hE0, {k[3:0], 4'h9});
      pause(4);
      chk("host_irq", hirq, 16'h0001 << k);
    end
    ext1 <= 8'h00;
    pause(4);
    chk("host_irq", hirq, 16'h0000);
    rst_n <= 1'h0;
    pause(2);
    rst_n <= 1'h1;
    pause(1);
    op(1'h0, 8'hE0, 8'h01);
    pause(2);
    wrap_up;
  end
endmodule // agpc_pin_cfg_tb

`default_nettype wire

// ===== agpc_pin_env.sv
/*
  far side of the pins: outside drivers meet the block's drivers.
  assumes the bench sets the outside levels; no pulls on these pins.
*/
`timescale 1ns/100ps
`default_nettype none

module agpc_pin_env
(
  // block side
  input  wire [6:0] p7_out,
  input  wire [6:0] p7_oe,
  input  wire [7:0] p1_out,
  input  wire [7:0] p1_oe,
  // outside drive
  input  wire [6:0] ext7,
  input  wire [7:0] ext1,
  // resolved levels
  output wire [6:0] p7_lvl,
  output wire [7:0] p1_lvl
);
  // no contention modelled: an enabled block driver wins
  assign p7_lvl = (p7_oe & p7_out) | (~p7_oe & ext7);
  assign p1_lvl = (p1_oe & p1_out) | (~p1_oe & ext1);
endmodule // agpc_pin_env

`default_nettype wire
